// ---- hw/sst_defines.svh ----
// Purpose: offsets, field positions and reset values of the status telegram
// Assumes: byte 0 of the telegram is the first byte on the wire
// Notes: definitions only
`ifndef SST_DEFINES_SVH
`define SST_DEFINES_SVH
`define SST_TLG_BYTES 17
`define SST_BYTE_MODE 0
`define SST_BYTE_FLAGS 1
`define SST_BYTE_ALIGN_H 2
`define SST_BYTE_ALIGN_V 4
`define SST_BYTE_TEMP 6
`define SST_BYTE_SCAN 8
`define SST_BYTE_REFL 12
`define SST_BYTE_FA_STATE 14
`define SST_BYTE_FA_PAIR12 15
`define SST_BYTE_FA_PAIR3 16
`define SST_REG_CTRL 4'h0
`define SST_REG_MODE_FLAGS 4'h1
`define SST_REG_ALIGN 4'h2
`define SST_REG_TEMP 4'h3
`define SST_REG_SCAN 4'h4
`define SST_REG_FA 4'h5
`define SST_REG_REFL 4'h6
`define SST_CTRL_FA_ACTIVE 0
`define SST_CTRL_MATCH1 1
`define SST_CTRL_MATCH2 2
`define SST_CTRL_SNAP 3
`define SST_FLAGS_USED 8'h1f
`define SST_SCAN_RESET 32'h0000_0000
`define SST_PAIR_MIN 4'h1
`define SST_PAIR_MAX 4'ha
`endif

// ---- hw/sst_pkg.sv ----
// Purpose: shared types of the scanner status telegram
// Assumes: nothing
// Notes: constants live in sst_defines.svh
package sst_pkg;
  typedef enum logic [2:0] {
    SST_IDLE = 3'b001,
    SST_ACK = 3'b010,
    SST_DONE = 3'b100
  } sst_bus_state_type;
  typedef logic [7:0] sst_byte_type;
endpackage

// ---- hw/sst_scan_counter.sv ----
// Purpose: 32-bit revolution counter
// Assumes: rev pulse is synchronous, one cycle per revolution
// Notes: wraps to zero on overflow
`timescale 1ns/1ps
`include "sst_defines.svh"
module sst_scan_counter (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic clk_en_in, // freezes state when low
  input wire logic rev_pulse_in, // one revolution done
  output logic [31:0] count_out // scan count
);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_out <= `SST_SCAN_RESET;
    end else if (clk_en_in && rev_pulse_in) begin
      count_out <= count_out + 32'h0000_0001;
    end
  end
endmodule

// ---- hw/sst_pair_field.sv ----
// Purpose: validated 4-bit field-pair number
// Assumes: input from same clock domain
// Notes: numbers outside 1..10 are shown as zero
`timescale 1ns/1ps
`include "sst_defines.svh"
module sst_pair_field (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic clk_en_in, // freezes state when low
  input wire logic [3:0] pair_in, // raw pair number
  output logic [3:0] pair_out // checked pair number
);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pair_out <= 4'h0;
    end else if (clk_en_in) begin
      if (pair_in >= `SST_PAIR_MIN && pair_in <= `SST_PAIR_MAX) begin
        pair_out <= pair_in;
      end else begin
        pair_out <= 4'h0;
      end
    end
  end
endmodule

// ---- hw/sst_status_telegram.sv ----
// Purpose: builds the cyclic status telegram of the scanner
// Assumes: Avalon-MM slave, word addresses, 32-bit data
// Notes: telegram bytes are presented as a flat 17-byte vector
//
// Summary of operation
// - byte 0 carries the eight-bit operating mode code
// - byte 1 bits 0-4: error, warning, contamination, pair fault, parked
// - signed 16-bit tilt H at 2, tilt V at 4, temperature at 6
// - 32-bit scan counter counts one per revolution
// - scan counter starts at zero after reset and wraps to zero
// - scan counter sent unsigned from byte 8, bits 0 to 31
// - reflector status bytes are always zero
// - byte 14: bit 0 active, bit 1 warn field free, bit 2 prot free
// - byte 14 bits 3-6 segment states, 1 means free; bit 7 zero
// - pair numbers 1-10: byte 15 low, byte 15 high, byte 16 low
// - byte 16 bits 6,7 show predefined pair matches; 4,5 zero
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "sst_defines.svh"
module sst_status_telegram
  import sst_pkg::*;
(
  input wire logic clk_in, // system clock 125 MHz
  input wire logic reset_n_in, // async reset, active low
  input wire logic clk_en_in, // freezes state when low
  input wire logic [7:0] operating_mode_code_in, // current mode
  input wire logic error_in, // error with switch-off
  input wire logic warning_in, // warning without shutdown
  input wire logic optics_contamination_flag_in, // cover dirty
  input wire logic pair_fault_in, // field-pair monitor fault
  input wire logic parked_in, // park request fulfilled
  input wire logic [15:0] align_h_in, // signed tilt horizontal
  input wire logic [15:0] align_v_in, // signed tilt vertical
  input wire logic [15:0] system_temperature_in, // signed temp
  input wire logic rev_pulse_in, // one revolution completed
  input wire logic func_a_warn_field_state_in, // 1 free
  input wire logic func_a_prot_field_state_in, // 1 free
  input wire logic func_a_warn_seg1_state_in, // 1 free
  input wire logic func_a_warn_seg2_state_in, // 1 free
  input wire logic func_a_prot_seg1_state_in, // 1 free
  input wire logic func_a_prot_seg2_state_in, // 1 free
  input wire logic [3:0] pair1_in, // first selected pair
  input wire logic [3:0] pair2_in, // second, superimposed
  input wire logic [3:0] pair3_in, // third, superimposed
  input wire logic [3:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic [135:0] telegram_out // 17 bytes, byte 0 low
);
  // ******************************
  // state
  // ******************************
  sst_bus_state_type state_r;
  logic [3:0] ctrl_r;
  logic [31:0] scan_count;
  logic [3:0] pair1_chk;
  logic [3:0] pair2_chk;
  logic [3:0] pair3_chk;
  logic [31:0] rd_nxt;
  logic [135:0] tlg_nxt;
  sst_byte_type flags_b;
  sst_byte_type fa_state_b;
  sst_byte_type fa_pair3_b;
  sst_byte_type ctrl_merged;

  function automatic sst_byte_type lane_merge(input sst_byte_type old_v,
      input sst_byte_type new_v, input logic en);
    lane_merge = en ? new_v : old_v;
  endfunction

  // ******************************
  // submodules
  // ******************************
  sst_scan_counter u_scan (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .rev_pulse_in(rev_pulse_in),
    .count_out(scan_count)
  );
  sst_pair_field u_pair1 (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .pair_in(pair1_in),
    .pair_out(pair1_chk)
  );
  sst_pair_field u_pair2 (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .pair_in(pair2_in),
    .pair_out(pair2_chk)
  );
  sst_pair_field u_pair3 (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .pair_in(pair3_in),
    .pair_out(pair3_chk)
  );

  // ******************************
  // telegram assembly
  // ******************************
  always_comb begin
    flags_b = {3'h0, parked_in, pair_fault_in,
        optics_contamination_flag_in, warning_in, error_in};
    flags_b = flags_b & `SST_FLAGS_USED;
    fa_state_b = {1'b0,
        func_a_prot_seg2_state_in, func_a_prot_seg1_state_in,
        func_a_warn_seg2_state_in, func_a_warn_seg1_state_in,
        func_a_prot_field_state_in, func_a_warn_field_state_in,
        ctrl_r[`SST_CTRL_FA_ACTIVE]};
    fa_pair3_b = {ctrl_r[`SST_CTRL_MATCH2], ctrl_r[`SST_CTRL_MATCH1],
        2'h0, pair3_chk};
    tlg_nxt = '0;
    tlg_nxt[`SST_BYTE_MODE*8 +: 8] = operating_mode_code_in;
    tlg_nxt[`SST_BYTE_FLAGS*8 +: 8] = flags_b;
    tlg_nxt[`SST_BYTE_ALIGN_H*8 +: 16] = align_h_in;
    tlg_nxt[`SST_BYTE_ALIGN_V*8 +: 16] = align_v_in;
    tlg_nxt[`SST_BYTE_TEMP*8 +: 16] = system_temperature_in;
    tlg_nxt[`SST_BYTE_SCAN*8 +: 32] = scan_count;
    tlg_nxt[`SST_BYTE_FA_STATE*8 +: 8] = fa_state_b;
    tlg_nxt[`SST_BYTE_FA_PAIR12*8 +: 8] = {pair2_chk, pair1_chk};
    tlg_nxt[`SST_BYTE_FA_PAIR3*8 +: 8] = fa_pair3_b;
  end

  // snapshot bit in ctrl freezes the telegram for a consistent read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      telegram_out <= '0;
    end else if (clk_en_in && !ctrl_r[`SST_CTRL_SNAP]) begin
      telegram_out <= tlg_nxt;
    end
  end

  // ******************************
  // register bus
  // ******************************
  always_comb begin
    case (avs_address)
      `SST_REG_CTRL: rd_nxt = {28'h0, ctrl_r};
      `SST_REG_MODE_FLAGS: rd_nxt = {16'h0, telegram_out[15:0]};
      `SST_REG_ALIGN: rd_nxt = telegram_out[47:16];
      `SST_REG_TEMP: rd_nxt = {16'h0, telegram_out[63:48]};
      `SST_REG_SCAN: rd_nxt = telegram_out[95:64];
      `SST_REG_FA: rd_nxt = {8'h0, telegram_out[135:112]};
      `SST_REG_REFL: rd_nxt = {16'h0, telegram_out[111:96]};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= SST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en_in) begin
      case (state_r)
        SST_IDLE: begin
          if (avs_read || avs_write) begin
            state_r <= SST_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_nxt : 32'h0000_0000;
          end
        end
        SST_ACK: begin
          state_r <= SST_DONE;
          avs_waitrequest <= 1'b1;
        end
        SST_DONE: begin
          state_r <= SST_IDLE;
        end
        default: begin
          state_r <= SST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign ctrl_merged = lane_merge({4'h0, ctrl_r}, avs_writedata[7:0],
      avs_byteenable[0]);

  // write lands in the ack cycle, the edge where the master sees wait low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r <= 4'h0;
    end else if (clk_en_in && state_r == SST_ACK && avs_write &&
        avs_address == `SST_REG_CTRL) begin
      ctrl_r <= ctrl_merged[3:0];
    end
  end
endmodule

// ---- verification/sst_status_telegram_properties.sv ----
// Purpose: port checks of the status telegram
// Assumes: clk_en_in held high by the bench
// Notes: bound from the bench top file
`timescale 1ns/1ps
module sst_status_telegram_properties (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [7:0] operating_mode_code_in, // mode
  input wire logic [15:0] system_temperature_in, // temperature
  input wire logic rev_pulse_in, // revolution pulse
  input wire logic func_a_warn_field_state_in, // 1 free
  input wire logic avs_read, // read request
  input wire logic avs_waitrequest, // stall
  input wire logic [135:0] telegram_out // telegram bytes
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_mode_byte: assert property (
    $past(reset_n_in) |-> telegram_out[7:0] == $past(operating_mode_code_in))
    else $error("mode byte wrong");
  chk_flags_rsvd: assert property (
    telegram_out[15:13] == 3'h0)
    else $error("flag reserved bits set");
  chk_temp_field: assert property (
    $past(reset_n_in) |-> telegram_out[63:48] == $past(system_temperature_in))
    else $error("temperature field wrong");
  chk_scan_step: assert property (
    rev_pulse_in |-> ##2
    telegram_out[95:64] == $past(telegram_out[95:64]) + 32'h1)
    else $error("scan count did not step");
  chk_scan_hold: assert property (
    !$past(rev_pulse_in, 2) |-> $stable(telegram_out[95:64]))
    else $error("scan count moved without pulse");
  chk_refl_zero: assert property (
    telegram_out[111:96] == 16'h0)
    else $error("reflector bytes not zero");
  chk_warn_free: assert property (
    $past(reset_n_in) |-> telegram_out[113] == $past(func_a_warn_field_state_in))
    else $error("warn field state wrong");
  chk_fa_rsvd: assert property (
    telegram_out[119] == 1'b0 && telegram_out[133:132] == 2'h0)
    else $error("function A reserved bits set");
  chk_pair_range: assert property (
    telegram_out[123:120] <= 4'ha && telegram_out[127:124] <= 4'ha &&
    telegram_out[131:128] <= 4'ha)
    else $error("pair number out of range");
  chk_bus_answer: assert property ($rose(avs_read) |-> ##[1:3] !avs_waitrequest)
    else $error("read not answered");
endmodule

// ---- verification/sst_fieldbus_model.sv ----
// Purpose: fieldbus controller reading the cyclic telegram
// Assumes: one byte fetched per cycle
// Notes: bytes past the telegram read zero
`timescale 1ns/1ps
module sst_fieldbus_model (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [135:0] telegram_in, // cyclic input data
  input wire logic [4:0] byte_sel_in, // byte to fetch
  output logic [7:0] byte_out // fetched byte
);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      byte_out <= 8'h00;
    else if (byte_sel_in < 5'd17)
      byte_out <= telegram_in[byte_sel_in * 8 +: 8];
    else
      byte_out <= 8'h00;
  end
endmodule

// ---- verification/sst_status_telegram_bench.sv ----
// Purpose: self-checking bench of the status telegram
// Assumes: clk_en_in and byte enables tied high
// Notes: wrap of the scan count is left to the checker
`timescale 1ns/1ps
`include "sst_defines.svh"
module sst_status_telegram_bench;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] operating_mode_code_in = 8'h00;
  logic [4:0] flg = 5'h00;
  logic [15:0] align_h_in = 16'h0, align_v_in = 16'h0;
  logic [15:0] system_temperature_in = 16'h0;
  logic rev_pulse_in = 1'b0;
  logic [5:0] fst = 6'h00;
  logic [3:0] pair1_in = 4'h0, pair2_in = 4'h0, pair3_in = 4'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [135:0] telegram_out;
  logic [4:0] fb_sel = 5'h00;
  logic [7:0] fb_byte;
  int bad_count = 0, tests_run = 0;
  always #4 clk_in = ~clk_in;
  sst_status_telegram i_sst_status_telegram (.clk_in, .reset_n_in,
    .clk_en_in(1'b1), .operating_mode_code_in, .error_in(flg[0]),
    .warning_in(flg[1]), .optics_contamination_flag_in(flg[2]),
    .pair_fault_in(flg[3]), .parked_in(flg[4]), .align_h_in, .align_v_in,
    .system_temperature_in, .rev_pulse_in,
    .func_a_warn_field_state_in(fst[0]), .func_a_prot_field_state_in(fst[1]),
    .func_a_warn_seg1_state_in(fst[2]), .func_a_warn_seg2_state_in(fst[3]),
    .func_a_prot_seg1_state_in(fst[4]), .func_a_prot_seg2_state_in(fst[5]),
    .pair1_in, .pair2_in, .pair3_in, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .telegram_out);
  sst_fieldbus_model i_sst_fieldbus_model (.clk_in, .reset_n_in,
    .telegram_in(telegram_out), .byte_sel_in(fb_sel), .byte_out(fb_byte));
  function automatic logic [3:0] pv(input int v);
    return (v >= 1 && v <= 10) ? v[3:0] : 4'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input int idx, input logic [7:0] exp);
    @(posedge clk_in);
    fb_sel <= idx[4:0];
    repeat (4) @(posedge clk_in);
    chk({24'h0, fb_byte}, {24'h0, exp});
  endtask
  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) bad_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    chk(telegram_out[95:64], 32'h0);
    for (int i = 0; i < 5; i++) begin
      flg <= 5'h01 << i;
      chk_byte(1, 8'h01 << i);
    end
    operating_mode_code_in <= 8'ha5;
    align_h_in <= 16'h8001;
    align_v_in <= 16'h7ffe;
    system_temperature_in <= 16'hff38;
    chk_byte(0, 8'ha5);
    chk({16'h0, telegram_out[31:16]}, 32'h0000_8001);
    chk(telegram_out[63:32], 32'hff38_7ffe);
    bus(1'b0, `SST_REG_MODE_FLAGS, 32'h0);
    chk(rd, 32'h0000_10a5);
    bus(1'b0, `SST_REG_ALIGN, 32'h0);
    chk(rd, 32'h7ffe_8001);
    bus(1'b0, `SST_REG_TEMP, 32'h0);
    chk(rd, 32'h0000_ff38);
    // snapshot freezes the telegram, so byte 1 keeps the old flags
    bus(1'b1, `SST_REG_CTRL, 32'hf);
    bus(1'b0, `SST_REG_CTRL, 32'h0);
    chk(rd, 32'h0000_000f);
    flg <= 5'h00;
    chk_byte(1, 8'h10);
    bus(1'b1, `SST_REG_CTRL, 32'h7);
    chk_byte(1, 8'h00);
    chk_byte(16, 8'hc0);
    for (int i = 0; i < 6; i++) begin
      fst <= 6'h01 << i;
      chk_byte(14, 8'h01 | (8'h02 << i));
    end
    bus(1'b1, `SST_REG_CTRL, 32'h0);
    for (int i = 0; i < 16; i++) begin
      pair1_in <= i[3:0];
      pair2_in <= 4'hf - i[3:0];
      pair3_in <= i[3:0];
      chk_byte(15, {pv(15 - i), pv(i)});
      chk_byte(16, {4'h0, pv(i)});
    end
    bus(1'b0, `SST_REG_FA, 32'h0);
    chk(rd, 32'h0000_0040);
    rev_pulse_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rev_pulse_in <= 1'b0;
    @(posedge clk_in);
    rev_pulse_in <= 1'b1;
    @(posedge clk_in);
    rev_pulse_in <= 1'b0;
    bus(1'b0, `SST_REG_SCAN, 32'h0);
    chk(rd, 32'h4);
    chk(telegram_out[95:64], 32'h4);
    bus(1'b0, `SST_REG_REFL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 4'hf, 32'hffff_ffff);
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    // reset in mid-run: the count must restart from zero and count again
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(telegram_out[95:64], 32'h0);
    rev_pulse_in <= 1'b1;
    @(posedge clk_in);
    rev_pulse_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(telegram_out[95:64], 32'h1);
    complete_run;
  end
endmodule
bind sst_status_telegram sst_status_telegram_properties i_props (.clk_in,
  .reset_n_in, .operating_mode_code_in, .system_temperature_in,
  .rev_pulse_in, .func_a_warn_field_state_in, .avs_read, .avs_waitrequest,
  .telegram_out);
